// ==== rtl/lpdcd_defines.svh ====
// Contract
// - deselect or no-op: nothing new taken, running operations continue, both identical.
// - cs,ras low, cas,we high: activate bank/row.
// - cs,cas low, ras,we high: read burst, bank and start column.
// - cs,cas,we low, ras high: write burst, bank and start column.
// - cs,we low, ras,cas high: burst terminate if cke high, else deep power-down.
// - cs,ras,cas low, we high: auto refresh if cke high, else self refresh.
// - precharge: a10 high all banks, else only the selected bank.
// - read/write with a10 high auto-precharges the row at burst end.
// - mode load: bank lines pick standard, extended or status register; address is op-code.
// - write byte with mask low is written; mask high leaves it unchanged.
// - burst terminate cuts most recent read, any bank, row stays open; code cuts only a read without auto precharge.
// - auto refresh uses internal row counter; address ignored; one command each.
// - in self refresh all inputs but cke ignored; cke held low throughout.
// - deep power-down removes array power; all data lost.
// - inputs sampled on rising edge of true clock where complement falls.
// - burst length programmable 2, 4, 8 or 16 from start column.
`ifndef LPDCD_DEFINES_SVH
`define LPDCD_DEFINES_SVH
`define LPDCD_A10           10
`define LPDCD_MRS_STD       2'h0
`define LPDCD_MRS_EXT       2'h2
`define LPDCD_MRS_STAT      2'h1
`define LPDCD_BL_FIELD_LSB  0
`define LPDCD_BL_RESET      3'h1
`define LPDCD_CLK_NS        50
`define LPDCD_TRP_NS        15
`define LPDCD_REFRESH_CYCLE_TIME_NS       72
`define LPDCD_MODE_LOAD_DELAY_NS       10
`define LPDCD_TRP_CYC       ((`LPDCD_TRP_NS + `LPDCD_CLK_NS - 1) / `LPDCD_CLK_NS)
`define LPDCD_REFRESH_CYCLE_TIME_CYC      ((`LPDCD_REFRESH_CYCLE_TIME_NS + `LPDCD_CLK_NS - 1) / `LPDCD_CLK_NS)
`define LPDCD_MODE_LOAD_DELAY_CYC      ((`LPDCD_MODE_LOAD_DELAY_NS + `LPDCD_CLK_NS - 1) / `LPDCD_CLK_NS)
`endif

// ==== rtl/lpdcd_pkg.sv ====
package lpdcd_pkg;
	typedef enum logic [3:0] {
		LPDCD_C_NONE  = 4'h0,
		LPDCD_C_ACT   = 4'h1,
		LPDCD_C_RD    = 4'h2,
		LPDCD_C_WR    = 4'h3,
		LPDCD_C_BST   = 4'h4,
		LPDCD_C_DPD   = 4'h5,
		LPDCD_C_PRE   = 4'h6,
		LPDCD_C_AREF  = 4'h7,
		LPDCD_C_SREF  = 4'h8,
		LPDCD_C_MRS   = 4'h9,
		LPDCD_C_BAD   = 4'ha
	} lpdcd_cmd_e;
	typedef enum logic [2:0] {
		LPDCD_B_IDLE  = 3'h0,
		LPDCD_B_ACT   = 3'h1,
		LPDCD_B_RD    = 3'h2,
		LPDCD_B_WR    = 3'h3,
		LPDCD_B_AP    = 3'h4,
		LPDCD_B_PRE   = 3'h5
	} lpdcd_bank_e;
	typedef enum logic [1:0] {
		LPDCD_M_RUN   = 2'h0,
		LPDCD_M_SREF  = 2'h1,
		LPDCD_M_DPD   = 2'h2
	} lpdcd_mode_e;
endpackage : lpdcd_pkg

// ==== rtl/lpdcd_cmd_if.sv ====
`timescale 1ns/10ps
// decoded command passed from the sampler to the bank tracker
interface lpdcd_cmd_if #(parameter int AW = 13);
	import lpdcd_pkg::*;
	logic            valid;
	lpdcd_cmd_e      cmd;
	logic [1:0]      bank;
	logic [AW-1:0]   addr;
	logic            cke;
	modport src (output valid, output cmd, output bank, output addr, output cke);
	modport dst (input valid, input cmd, input bank, input addr, input cke);
endinterface : lpdcd_cmd_if

// ==== rtl/lpdcd_sampler.sv ====
`timescale 1ns/10ps
`include "lpdcd_defines.svh"
// synchronises the pins, finds the rising link clock edge, decodes the command
module lpdcd_sampler import lpdcd_pkg::*; #(
	parameter int AW = 13
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          diff_clock_true,
	input  wire logic          diff_clock_comp,
	input  wire logic          cs_n,
	input  wire logic          ras_n,
	input  wire logic          cas_n,
	input  wire logic          we_n,
	input  wire logic          cke,
	input  wire logic          bank_select_0,
	input  wire logic          bank_select_1,
	input  wire logic [AW-1:0] addr,
	lpdcd_cmd_if.src           cmd_o
);
	localparam int W = AW + 9;
	logic [W-1:0] s1_q, s1_d, s2_q, s2_d;
	logic         ck_prev_q, ck_prev_d;
	logic         rise;
	lpdcd_cmd_e   dec;

	// two-stage synchroniser; only stage two is looked at
	always_comb begin
		s1_d = {diff_clock_true, diff_clock_comp, cs_n, ras_n, cas_n, we_n, cke,
			bank_select_1, bank_select_0, addr};
		s2_d = s1_q;
		ck_prev_d = s2_q[W-1];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q      <= '0;
			s2_q      <= '0;
			ck_prev_q <= 1'b0;
		end else begin
			s1_q      <= s1_d;
			s2_q      <= s2_d;
			ck_prev_q <= ck_prev_d;
		end
	end

	// true rises while complement is low: the positive crossing
	assign rise = s2_q[W-1] & ~ck_prev_q & ~s2_q[W-2];

	// command decode from cs/ras/cas/we and cke
	always_comb begin
		unique case (s2_q[W-3:W-6])
			4'hf, 4'he, 4'hd, 4'hc,
			4'hb, 4'ha, 4'h9, 4'h8: dec = LPDCD_C_NONE;
			4'h7: dec = LPDCD_C_NONE;
			4'h3: dec = LPDCD_C_ACT;
			4'h5: dec = LPDCD_C_RD;
			4'h4: dec = LPDCD_C_WR;
			4'h6: dec = s2_q[W-7] ? LPDCD_C_BST : LPDCD_C_DPD;
			4'h2: dec = LPDCD_C_PRE;
			4'h1: dec = s2_q[W-7] ? LPDCD_C_AREF : LPDCD_C_SREF;
			4'h0: dec = LPDCD_C_MRS;
		endcase
		// every other command needs cke high
		if (!s2_q[W-7] && dec != LPDCD_C_NONE && dec != LPDCD_C_DPD && dec != LPDCD_C_SREF)
			dec = LPDCD_C_BAD;
	end

	assign cmd_o.valid = rise;
	assign cmd_o.cmd   = dec;
	assign cmd_o.bank  = s2_q[AW+1:AW];
	assign cmd_o.addr  = s2_q[AW-1:0];
	assign cmd_o.cke   = s2_q[W-7];
endmodule : lpdcd_sampler

// ==== rtl/lpdcd_decoder.sv ====
`timescale 1ns/10ps
`include "lpdcd_defines.svh"
// bank state tracker and command interpreter of the memory device
module lpdcd_decoder import lpdcd_pkg::*; #(
	parameter int AW   = 13,
	parameter int RW   = 13,
	parameter int CW   = 10,
	parameter int NB   = 4
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          diff_clock_true,
	input  wire logic          diff_clock_comp,
	input  wire logic          cs_n,
	input  wire logic          ras_n,
	input  wire logic          cas_n,
	input  wire logic          we_n,
	input  wire logic          cke,
	input  wire logic          bank_select_0,
	input  wire logic          bank_select_1,
	input  wire logic [AW-1:0] addr,
	input  wire logic [1:0]    write_byte_mask,
	output logic [NB-1:0]      bank_open,
	output logic [NB*RW-1:0]   open_row,
	output logic               burst_active,
	output logic               burst_is_write,
	output logic [1:0]         burst_bank,
	output logic [CW-1:0]      burst_col,
	output logic               burst_step,
	output logic [1:0]         byte_write_en,
	output logic               array_powered,
	output logic               self_refresh,
	output logic               refresh_pulse,
	output logic [RW-1:0]      refresh_row,
	output logic               mode_load_pulse,
	output logic [1:0]         mode_load_sel,
	output logic [AW-1:0]      mode_load_data,
	output logic [2:0]         burst_len_code,
	output logic               illegal_cmd
);
	lpdcd_cmd_if #(.AW(AW)) cif ();

	lpdcd_sampler #(.AW(AW)) u_samp (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.diff_clock_true (diff_clock_true),
		.diff_clock_comp (diff_clock_comp),
		.cs_n            (cs_n),
		.ras_n           (ras_n),
		.cas_n           (cas_n),
		.we_n            (we_n),
		.cke             (cke),
		.bank_select_0   (bank_select_0),
		.bank_select_1   (bank_select_1),
		.addr            (addr),
		.cmd_o           (cif.src)
	);

	localparam logic [3:0] PRECHARGE_PERIOD  = 4'(`LPDCD_TRP_CYC);
	localparam logic [3:0] REFRESH_CYCLE_TIME = 4'(`LPDCD_REFRESH_CYCLE_TIME_CYC);
	localparam logic [3:0] MODE_LOAD_DELAY = 4'(`LPDCD_MODE_LOAD_DELAY_CYC);

	lpdcd_bank_e          bst_q [NB], bst_d [NB];
	logic [3:0]           btim_q [NB], btim_d [NB];
	logic [RW-1:0]        row_q [NB], row_d [NB];
	logic [3:0]           gtim_q, gtim_d;
	lpdcd_mode_e          mode_q, mode_d;
	logic                 ba_q, ba_d, bw_q, bw_d;
	logic [1:0]           bb_q, bb_d;
	logic [CW-1:0]        bc_q, bc_d;
	logic [4:0]           left_q, left_d;
	logic                 step_q, step_d;
	logic [1:0]           bwe_q, bwe_d;
	logic [RW-1:0]        rrow_q, rrow_d;
	logic                 rp_q, rp_d, mp_q, mp_d, ill_q, ill_d;
	logic [1:0]           msel_q, msel_d;
	logic [AW-1:0]        mdat_q, mdat_d;
	logic [2:0]           bl_q, bl_d;
	logic                 all_idle;
	logic [1:0]           b;
	logic                 ap;

	// burst length code 1..4 gives 2,4,8,16 locations
	function automatic logic [4:0] bl_len(input logic [2:0] code);
		unique case (code)
			3'h1: bl_len = 5'h02;
			3'h2: bl_len = 5'h04;
			3'h3: bl_len = 5'h08;
			default: bl_len = 5'h10;
		endcase
	endfunction : bl_len

	always_comb begin
		all_idle = (gtim_q == 4'h0);
		for (int i = 0; i < NB; i++)
			if (bst_q[i] != LPDCD_B_IDLE)
				all_idle = 1'b0;
	end

	assign b  = cif.bank;
	assign ap = cif.addr[`LPDCD_A10];

	// command interpretation and bank state updates
	always_comb begin
		bst_d = bst_q;
		btim_d = btim_q;
		row_d = row_q;
		gtim_d = (gtim_q != 4'h0) ? gtim_q - 4'h1 : gtim_q;
		mode_d = mode_q;
		ba_d = ba_q;
		bw_d = bw_q;
		bb_d = bb_q;
		bc_d = bc_q;
		left_d = left_q;
		step_d = 1'b0;
		bwe_d = 2'h0;
		rrow_d = rrow_q;
		rp_d = 1'b0;
		mp_d = 1'b0;
		ill_d = 1'b0;
		msel_d = msel_q;
		mdat_d = mdat_q;
		bl_d = bl_q;
		// precharge timers; idle only after the period
		for (int i = 0; i < NB; i++) begin
			if (btim_q[i] != 4'h0)
				btim_d[i] = btim_q[i] - 4'h1;
			else if (bst_q[i] == LPDCD_B_PRE)
				bst_d[i] = LPDCD_B_IDLE;
		end
		if (cif.valid && ba_q) begin
			// one location per link edge; end closes auto precharge rows
			step_d = 1'b1;
			bc_d = bc_q + CW'(1);
			if (bw_q)
				bwe_d = ~write_byte_mask;
			left_d = left_q - 5'h1;
			if (left_q == 5'h1) begin
				ba_d = 1'b0;
				if (bst_q[bb_q] == LPDCD_B_AP) begin
					bst_d[bb_q] = LPDCD_B_PRE;
					btim_d[bb_q] = PRECHARGE_PERIOD;
				end else if (bst_q[bb_q] != LPDCD_B_IDLE)
					bst_d[bb_q] = LPDCD_B_ACT;
			end
		end
		if (mode_q == LPDCD_M_SREF) begin
			// only cke is watched while self refreshing
			if (cif.cke)
				mode_d = LPDCD_M_RUN;
		end else if (mode_q == LPDCD_M_DPD) begin
			if (cif.cke)
				mode_d = LPDCD_M_RUN;
		end else if (cif.valid && cif.cmd != LPDCD_C_NONE) begin
			// refresh or mode load in progress forbids any command
			if (gtim_q != 4'h0)
				ill_d = 1'b1;
			else unique case (cif.cmd)
				LPDCD_C_ACT: begin
					if (bst_q[b] != LPDCD_B_IDLE)
						ill_d = 1'b1;
					else begin
						bst_d[b] = LPDCD_B_ACT;
						row_d[b] = cif.addr[RW-1:0];
					end
				end
				LPDCD_C_RD, LPDCD_C_WR: begin
					if (bst_q[b] == LPDCD_B_IDLE || bst_q[b] == LPDCD_B_PRE ||
						bst_q[b] == LPDCD_B_AP)
						ill_d = 1'b1;
					else begin
						if (ba_q && bst_q[bb_q] != LPDCD_B_AP && bb_q != b)
							bst_d[bb_q] = LPDCD_B_ACT;
						bst_d[b] = ap ? LPDCD_B_AP :
							((cif.cmd == LPDCD_C_RD) ? LPDCD_B_RD : LPDCD_B_WR);
						ba_d = 1'b1;
						bw_d = (cif.cmd == LPDCD_C_WR);
						bb_d = b;
						bc_d = cif.addr[CW-1:0];
						left_d = bl_len(bl_q);
					end
				end
				LPDCD_C_BST: begin
					// only a running read without auto precharge may be cut
					if (!ba_q || bw_q || bst_q[bb_q] != LPDCD_B_RD)
						ill_d = 1'b1;
					else begin
						ba_d = 1'b0;
						bst_d[bb_q] = LPDCD_B_ACT;
					end
				end
				LPDCD_C_PRE: begin
					for (int i = 0; i < NB; i++)
						if (ap || i == int'(b)) begin
							if (bst_q[i] != LPDCD_B_IDLE && bst_q[i] != LPDCD_B_PRE) begin
								bst_d[i] = LPDCD_B_PRE;
								btim_d[i] = PRECHARGE_PERIOD;
								if (ba_q && bb_q == 2'(i))
									ba_d = 1'b0;
							end
						end
				end
				LPDCD_C_AREF, LPDCD_C_SREF: begin
					if (!all_idle || ba_q)
						ill_d = 1'b1;
					else begin
						rp_d = 1'b1;
						rrow_d = rrow_q + RW'(1);
						if (cif.cmd == LPDCD_C_AREF)
							gtim_d = REFRESH_CYCLE_TIME;
						else
							mode_d = LPDCD_M_SREF;
					end
				end
				LPDCD_C_MRS: begin
					if (!all_idle || ba_q || cif.bank == 2'h3)
						ill_d = 1'b1;
					else begin
						mp_d = 1'b1;
						msel_d = cif.bank;
						mdat_d = cif.addr;
						gtim_d = MODE_LOAD_DELAY;
						if (cif.bank == `LPDCD_MRS_STD)
							bl_d = cif.addr[`LPDCD_BL_FIELD_LSB +: 3];
					end
				end
				LPDCD_C_DPD: begin
					// array power gone: all banks and bursts are dropped
					mode_d = LPDCD_M_DPD;
					ba_d = 1'b0;
					for (int i = 0; i < NB; i++) begin
						bst_d[i] = LPDCD_B_IDLE;
						btim_d[i] = 4'h0;
					end
				end
				default: ill_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NB; i++) begin
				bst_q[i]  <= LPDCD_B_IDLE;
				btim_q[i] <= 4'h0;
				row_q[i]  <= '0;
			end
			gtim_q <= 4'h0;
			mode_q <= LPDCD_M_RUN;
			ba_q   <= 1'b0;
			bw_q   <= 1'b0;
			bb_q   <= 2'h0;
			bc_q   <= '0;
			left_q <= 5'h0;
			step_q <= 1'b0;
			bwe_q  <= 2'h0;
			rrow_q <= '0;
			rp_q   <= 1'b0;
			mp_q   <= 1'b0;
			ill_q  <= 1'b0;
			msel_q <= 2'h0;
			mdat_q <= '0;
			bl_q   <= `LPDCD_BL_RESET;
		end else begin
			bst_q  <= bst_d;
			btim_q <= btim_d;
			row_q  <= row_d;
			gtim_q <= gtim_d;
			mode_q <= mode_d;
			ba_q   <= ba_d;
			bw_q   <= bw_d;
			bb_q   <= bb_d;
			bc_q   <= bc_d;
			left_q <= left_d;
			step_q <= step_d;
			bwe_q  <= bwe_d;
			rrow_q <= rrow_d;
			rp_q   <= rp_d;
			mp_q   <= mp_d;
			ill_q  <= ill_d;
			msel_q <= msel_d;
			mdat_q <= mdat_d;
			bl_q   <= bl_d;
		end
	end

	// status outputs
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			bank_open[i] = (bst_q[i] == LPDCD_B_ACT) || (bst_q[i] == LPDCD_B_RD) ||
				(bst_q[i] == LPDCD_B_WR) || (bst_q[i] == LPDCD_B_AP);
			open_row[i*RW +: RW] = row_q[i];
		end
	end
	assign burst_active    = ba_q;
	assign burst_is_write  = bw_q;
	assign burst_bank      = bb_q;
	assign burst_col       = bc_q;
	assign burst_step      = step_q;
	assign byte_write_en   = bwe_q;
	assign array_powered   = (mode_q != LPDCD_M_DPD);
	assign self_refresh    = (mode_q == LPDCD_M_SREF);
	assign refresh_pulse   = rp_q;
	assign refresh_row     = rrow_q;
	assign mode_load_pulse = mp_q;
	assign mode_load_sel   = msel_q;
	assign mode_load_data  = mdat_q;
	assign burst_len_code  = bl_q;
	assign illegal_cmd     = ill_q;
endmodule : lpdcd_decoder

// ==== test/lpdcd_decoder_chk.sv ====
`timescale 1ns/10ps
// port-level watch on pulses and bank state of the decoder
module lpdcd_decoder_chk #(
	parameter int RW = 13,
	parameter int NB = 4
) (
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic [NB-1:0] bank_open,
	input wire logic          burst_active,
	input wire logic          burst_is_write,
	input wire logic          burst_step,
	input wire logic [1:0]    byte_write_en,
	input wire logic          array_powered,
	input wire logic          self_refresh,
	input wire logic          refresh_pulse,
	input wire logic [RW-1:0] refresh_row,
	input wire logic          mode_load_pulse,
	input wire logic [1:0]    mode_load_sel,
	input wire logic          illegal_cmd
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	ill_pulse_a: assert property (illegal_cmd |=> !illegal_cmd)
		else $error("illegal flag held longer than one cycle");
	ref_pulse_a: assert property (refresh_pulse |=> !refresh_pulse)
		else $error("refresh pulse held longer than one cycle");
	mode_pulse_a: assert property (mode_load_pulse |=> !mode_load_pulse)
		else $error("mode load pulse held longer than one cycle");
	mode_sel_a: assert property (mode_load_pulse |-> mode_load_sel != 2'h3)
		else $error("mode load to an unused register select");
	byte_en_a: assert property (byte_write_en != 2'h0 |-> burst_step && burst_is_write)
		else $error("byte enable outside a write step");
	step_src_a: assert property (burst_step |-> $past(burst_active))
		else $error("burst step without a running burst");
	row_count_a: assert property ($changed(refresh_row) |-> refresh_row == $past(refresh_row) + 1'b1)
		else $error("refresh row moved by other than one");
	sref_hold_a: assert property (self_refresh && $past(self_refresh) |-> $stable(bank_open))
		else $error("bank state changed in self refresh");
	dpd_empty_a: assert property (!array_powered |-> bank_open == '0)
		else $error("open bank while array unpowered");
	mode_excl_a: assert property (!(self_refresh && !array_powered))
		else $error("self refresh and power-down together");
	// main scenarios reached
	cover property (byte_write_en == 2'h3);
	cover property ($rose(self_refresh));
	cover property (illegal_cmd);
endmodule : lpdcd_decoder_chk

bind lpdcd_decoder lpdcd_decoder_chk #(.RW(RW), .NB(NB)) chk_u (.clk, .sys_rst, .bank_open,
	.burst_active, .burst_is_write, .burst_step, .byte_write_en, .array_powered, .self_refresh,
	.refresh_pulse, .refresh_row, .mode_load_pulse, .mode_load_sel, .illegal_cmd);

// ==== test/lpdcd_ctrl_model.sv ====
`timescale 1ns/10ps
// memory controller side: one command per link clock period
module lpdcd_ctrl_model (
	input  wire logic   clk,
	output logic        diff_clock_true,
	output logic        diff_clock_comp,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic        cke,
	output logic        bank_select_0,
	output logic        bank_select_1,
	output logic [12:0] addr,
	output logic [1:0]  write_byte_mask
);
	// link clock parked low between frames
	initial begin
		{diff_clock_true, diff_clock_comp} = 2'h1;
		{cs_n, ras_n, cas_n, we_n, cke} = 5'h1f;
		{bank_select_1, bank_select_0, addr, write_byte_mask} = '0;
	end
	// c is cs,ras,cas,we; callers keep bank order and waits, 9 clk apart covers them
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
			input logic k, input logic [1:0] m);
		// each frame holds the lines four clk past its one rising link edge, so the sampler sees them stable
		@(negedge clk);
		{cs_n, ras_n, cas_n, we_n} = c;
		{bank_select_1, bank_select_0} = b;
		addr = a;
		cke = k;
		write_byte_mask = m;
		repeat (4) @(negedge clk);
		{diff_clock_true, diff_clock_comp} = 2'h2;
		repeat (4) @(negedge clk);
		{diff_clock_true, diff_clock_comp} = 2'h1;
		// released lines show the inverse, so stale values never look valid
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = ~c[2:0];
		{bank_select_1, bank_select_0} = ~b;
		addr = ~a;
		write_byte_mask = ~m;
	endtask : issue
endmodule : lpdcd_ctrl_model

// ==== test/test_lpdcd_decoder.sv ====
`timescale 1ns/10ps
// scenario bench for the command decoder
module test_lpdcd_decoder;
	localparam logic [3:0] C_NOP = 4'h7, C_DES = 4'hf, C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4;
	localparam logic [3:0] C_BST = 4'h6, C_PRE = 4'h2, C_REF = 4'h1, C_MRS = 4'h0;
	logic        clk, sys_rst, diff_clock_true, diff_clock_comp, cs_n, ras_n, cas_n, we_n;
	logic        cke, bank_select_0, bank_select_1, burst_active, burst_is_write, burst_step;
	logic        array_powered, self_refresh, refresh_pulse, mode_load_pulse, illegal_cmd;
	logic [12:0] addr, refresh_row, mode_load_data;
	logic [1:0]  write_byte_mask, burst_bank, byte_write_en, mode_load_sel, wq[$];
	logic [3:0]  bank_open;
	logic [51:0] open_row;
	logic [9:0]  burst_col;
	logic [2:0]  burst_len_code;
	int          n_errors = 0, cmp_count = 0, n_ill = 0, n_ref = 0, n_mlp = 0;

	lpdcd_ctrl_model ctrl_u (.clk, .diff_clock_true, .diff_clock_comp, .cs_n, .ras_n, .cas_n,
		.we_n, .cke, .bank_select_0, .bank_select_1, .addr, .write_byte_mask);
	lpdcd_decoder dut_u (.clk, .sys_rst, .diff_clock_true, .diff_clock_comp, .cs_n, .ras_n,
		.cas_n, .we_n, .cke, .bank_select_0, .bank_select_1, .addr, .write_byte_mask, .bank_open,
		.open_row, .burst_active, .burst_is_write, .burst_bank, .burst_col, .burst_step,
		.byte_write_en, .array_powered, .self_refresh, .refresh_pulse, .refresh_row,
		.mode_load_pulse, .mode_load_sel, .mode_load_data, .burst_len_code, .illegal_cmd);

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// pulses last one clk, so they are counted here as they pass
	always @(posedge clk) begin
		if (illegal_cmd === 1'b1) n_ill++;
		if (refresh_pulse === 1'b1) n_ref++;
		if (mode_load_pulse === 1'b1) n_mlp++;
		if (burst_step === 1'b1 && burst_is_write === 1'b1) wq.push_back(byte_write_en);
	end
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// one command, then let the synchroniser and the answer land
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
			input logic k = 1'b1, input logic [1:0] m = 2'h0);
		ctrl_u.issue(c, b, a, k, m);
		repeat (2) @(negedge clk);
	endtask : cmd
	task automatic t_write();
		chk("array_powered", 1'b1, array_powered);
		chk("burst_len_code", 3'h1, burst_len_code);
		cmd(C_ACT, 2'h1, 13'h0123);
		cmd(C_NOP, 2'h2, 13'h1fff);
		cmd(C_DES, 2'h3, 13'h0400);
		chk("bank_open", 4'h2, bank_open);
		chk("open_row", 13'h0123, open_row[25:13]);
		wq.delete();
		cmd(C_WR, 2'h1, 13'h0004);
		chk("burst_is_write", 1'b1, burst_is_write);
		chk("burst_col", 10'h004, burst_col);
		cmd(C_NOP, 2'h0, 13'h0, 1'b1, 2'h2);
		cmd(C_NOP, 2'h0, 13'h0, 1'b1, 2'h0);
		chk("burst_active", 1'b0, burst_active);
		chk("byte_en0", 2'h1, wq[0]);
		chk("byte_en1", 2'h3, wq[1]);
		chk("bank_open", 4'h2, bank_open);
		$display("t_write done");
	endtask : t_write
	task automatic t_read_ap();
		cmd(C_RD, 2'h1, 13'h0408);
		chk("burst_bank", 2'h1, burst_bank);
		chk("burst_is_write", 1'b0, burst_is_write);
		cmd(C_NOP, 2'h0, 13'h0);
		cmd(C_NOP, 2'h0, 13'h0);
		cmd(C_NOP, 2'h0, 13'h0);
		chk("bank_open", 4'h0, bank_open);
		$display("t_read_ap done");
	endtask : t_read_ap
	task automatic t_mrs();
		logic [1:0] sel [3];
		sel = '{2'h2, 2'h1, 2'h0};
		for (int i = 0; i < 3; i++) begin
			cmd(C_MRS, sel[i], 13'h0023);
			chk("mode_load_sel", sel[i], mode_load_sel);
			chk("mode_load_data", 13'h0023, mode_load_data);
		end
		chk("burst_len_code", 3'h3, burst_len_code);
		cmd(C_MRS, 2'h3, 13'h0001);
		chk("illegal count", 1, n_ill);
		chk("mode load count", 3, n_mlp);
		$display("t_mrs done");
	endtask : t_mrs
	// burst terminate only after a read without auto precharge
	task automatic t_bst();
		cmd(C_ACT, 2'h0, 13'h0005);
		cmd(C_ACT, 2'h2, 13'h0007);
		cmd(C_RD, 2'h0, 13'h0000);
		cmd(C_BST, 2'h3, 13'h1fff);
		chk("burst_active", 1'b0, burst_active);
		chk("bank_open", 4'h5, bank_open);
		$display("t_bst done");
	endtask : t_bst
	task automatic t_pre();
		cmd(C_PRE, 2'h2, 13'h0000);
		chk("bank_open", 4'h1, bank_open);
		cmd(C_PRE, 2'h3, 13'h0400);
		chk("bank_open", 4'h0, bank_open);
		cmd(C_RD, 2'h3, 13'h0000);
		chk("illegal count", 2, n_ill);
		$display("t_pre done");
	endtask : t_pre
	// refreshes right before self refresh, the recommended habit
	task automatic t_refresh();
		cmd(C_REF, 2'h1, 13'h1234);
		chk("refresh_row", 13'h0001, refresh_row);
		cmd(C_REF, 2'h2, 13'h0abc);
		chk("refresh_row", 13'h0002, refresh_row);
		cmd(C_REF, 2'h0, 13'h0000, 1'b0);
		chk("self_refresh", 1'b1, self_refresh);
		cmd(C_ACT, 2'h1, 13'h0005, 1'b0);
		chk("bank_open", 4'h0, bank_open);
		chk("refresh count", 3, n_ref);
		cmd(C_NOP, 2'h0, 13'h0000);
		chk("self_refresh", 1'b0, self_refresh);
		$display("t_refresh done");
	endtask : t_refresh
	task automatic t_dpd();
		cmd(C_BST, 2'h0, 13'h0000, 1'b0);
		chk("array_powered", 1'b0, array_powered);
		cmd(C_NOP, 2'h0, 13'h0000);
		$display("t_dpd done");
	endtask : t_dpd
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	// main sequence; every task waits a whole link frame per command
	initial begin
		sys_rst = 1'b1;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		t_write();
		t_read_ap();
		t_mrs();
		t_bst();
		t_pre();
		t_refresh();
		t_dpd();
		results();
	end
	// 28 commands of 11 clk each; about thirteen times that is a hang
	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired");
		results();
	end
endmodule : test_lpdcd_decoder
